//--- tb_tci_top.sv
`timescale 1ns/10ps
module tb_tci_top;
    import tci_pkg::*;
    // ==========================================================
    // signals
    logic clock = 1'h0, rst = 1'h1, cur_req_wr = 1'h0, out_short = 1'h0, stage_hot = 1'h0;
    logic fault_clear_input = 1'h0, hardware_enable_input = 1'h0, sw_mode = 1'h0;
    logic sw_start = 1'h0, rx_event = 1'h0, tx_event = 1'h0, host_conn = 1'h0, safe_req = 1'h0;
    logic [MV_W-1:0] sense_mv = 12'h3E8;
    logic [UA_W-1:0] cur_req_ua = 13'h0000, cur_set_ua;
    logic signed [T_W-1:0] temp_deci = 16'sh0000, setp_deci = 16'sh0000;
    logic [5:0] rail_ok = 6'h00, led_rail;
    logic sensor_err, short_trip, final_enable, led_err, led_stat, led_cpu;
    logic led_red, led_yel, led_grn, led_rx, led_tx, err_done, stat_done;
    logic [3:0] err_n, stat_n, n;
    int error_cnt = 0, check_count = 0, k, hi, tg, t_r, t_y, t_g;
    logic [UA_W-1:0] w_req [5] = '{13'h07D0, 13'h0FA1, 13'h0063, 13'h0FA0, 13'h0064};
    logic [UA_W-1:0] w_exp [5] = '{13'h07D0, 13'h07D0, 13'h07D0, 13'h0FA0, 13'h0064};
    logic [MV_W-1:0] s_mv [4] = '{12'h04F, 12'h050, 12'h8FC, 12'h8FD};
    logic [MV_W-1:0] e_mv [5] = '{12'h04F, 12'h3E8, 12'h3E8, 12'h04F, 12'h3E8};
    logic [1:0] e_sh [5] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h3};
    logic [3:0] e_n [5] = '{4'h1, 4'h2, 4'h3, 4'h1, 4'h2};

    // short timings keep the run small; flash gaps stay under the reader gap
    localparam int FLC = 4, PAC = 10, BTC = 5, HBC = 6, ACC = 3, LKC = 5;
    tci_top #(.FLASH_CYCLES(FLC), .PAUSE_CYCLES(PAC), .BOOT_CYCLES(BTC), .HEART_CYCLES(HBC),
        .ACT_CYCLES(ACC), .LINK_CYCLES(LKC)) DUT (.clock(clock), .rst(rst), .sense_mv(sense_mv),
        .cur_req_ua(cur_req_ua), .cur_req_wr(cur_req_wr), .cur_set_ua(cur_set_ua),
        .sensor_err(sensor_err), .out_short(out_short), .stage_hot(stage_hot),
        .fault_clear_input(fault_clear_input), .short_trip(short_trip),
        .hardware_enable_input(hardware_enable_input), .sw_mode(sw_mode), .sw_start(sw_start),
        .temp_deci(temp_deci), .setp_deci(setp_deci), .final_enable(final_enable),
        .rx_event(rx_event), .tx_event(tx_event), .host_conn(host_conn), .safe_req(safe_req),
        .rail_ok(rail_ok), .led_err(led_err), .led_stat(led_stat), .led_cpu(led_cpu),
        .led_red(led_red), .led_yel(led_yel), .led_grn(led_grn), .led_rx(led_rx),
        .led_tx(led_tx), .led_rail(led_rail));
    tci_flash_reader err_rd (.clock(clock), .rst(rst), .led(led_err),
        .flashes(err_n), .group_done(err_done));
    tci_flash_reader stat_rd (.clock(clock), .rst(rst), .led(led_stat),
        .flashes(stat_n), .group_done(stat_done));

    initial begin
        forever #5 clock = ~clock;
    end
    // ==========================================================
    // helpers
    task automatic tick(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : tick
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_bit
    task automatic cmp_ua(input string what, input logic [12:0] exp, input logic [12:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_ua
    task automatic watch(ref logic s, input int c, output int h, output int t);
        logic p;
        h = 0;
        t = 0;
        p = s;
        repeat (c) begin
            tick(1);
            h += (s === 1'h1);
            t += (s !== p);
            p = s;
        end
    endtask : watch
    // second finished group is whole; the first may be cut by the change
    task automatic wait_group(input logic st, output logic [3:0] f);
        int seen;
        seen = 0;
        f = 4'hF;
        for (int i = 0; i < 300 && seen < 2; i++) begin
            tick(1);
            if ((st ? stat_done : err_done) === 1'h1) begin
                seen++;
                f = st ? stat_n : err_n;
            end
        end
        if (seen < 2) begin
            error_cnt++;
            $display("FAIL flash group timeout");
            wrap_up();
        end
    endtask : wait_group
    task automatic clear_faults();
        @(posedge clock);
        sense_mv <= 12'h3E8;
        {out_short, stage_hot} <= 2'h0;
        fault_clear_input <= 1'h1;
        tick(3);
        @(posedge clock);
        fault_clear_input <= 1'h0;
        tick(1);
    endtask : clear_faults
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    // ==========================================================
    // tests
    initial begin
        t_r = -1;
        t_y = -1;
        t_g = -1;
        repeat (6) @(posedge clock);
        rst <= 1'h0;
        #1;
        cmp_ua("cur_set_ua", 13'h03E8, cur_set_ua);
        for (k = 0; k < 60; k++) begin
            tick(1);
            cmp_bit("one boot led", 1'h1, $countones({led_red, led_yel, led_grn}) <= 1);
            if (led_red === 1'h1 && t_r < 0) t_r = k;
            if (led_yel === 1'h1 && t_y < 0) t_y = k;
            if (led_grn === 1'h1 && t_g < 0) t_g = k;
        end
        cmp_bit("boot order", 1'h1, t_r >= 0 && t_r < t_y && t_y < t_g);
        watch(led_cpu, 36, hi, tg);
        cmp_bit("cpu toggles", 1'h1, tg == 36 / HBC);
        $display("test boot done");
        for (k = 0; k < 5; k++) begin
            @(posedge clock);
            cur_req_ua <= w_req[k];
            cur_req_wr <= 1'h1;
            @(posedge clock);
            cur_req_wr <= 1'h0;
            tick(1);
            cmp_ua("cur_set_ua", w_exp[k], cur_set_ua);
        end
        $display("test current done");
        for (k = 0; k < 4; k++) begin
            @(posedge clock);
            sense_mv <= s_mv[k];
            tick(2);
            cmp_bit("sensor_err", k == 0 || k == 3, sensor_err);
            @(posedge clock);
            sense_mv <= 12'h3E8;
            tick(2);
            cmp_bit("sensor_err held", k == 0 || k == 3, sensor_err);
            clear_faults();
            cmp_bit("sensor_err cleared", 1'h0, sensor_err);
        end
        $display("test thresholds done");
        for (k = 0; k < 5; k++) begin
            @(posedge clock);
            sense_mv <= e_mv[k];
            {out_short, stage_hot} <= e_sh[k];
            #1;
            cmp_bit("short_trip", e_sh[k][1], short_trip);
            wait_group(1'h0, n);
            cmp_ua("err flashes", {9'h000, e_n[k]}, {9'h000, n});
            clear_faults();
        end
        watch(led_err, 40, hi, tg);
        cmp_bit("err dark", 1'h1, hi == 0);
        $display("test error codes done");
        for (k = 0; k < 8; k++) begin
            @(posedge clock);
            {sw_mode, hardware_enable_input, sw_start} <= k[2:0];
            tick(2);
            cmp_bit("final_enable", k[2] ? k[1] & k[0] : k[1], final_enable);
        end
        $display("test enable done");
        @(posedge clock);
        {sw_mode, hardware_enable_input} <= 2'h1;
        setp_deci <= 16'sh00FA;
        temp_deci <= 16'sh0104;
        tick(4);
        watch(led_stat, 30, hi, tg);
        cmp_bit("stat steady", 1'h1, hi == 30);
        @(posedge clock);
        temp_deci <= 16'sh00EF;
        wait_group(1'h1, n);
        cmp_ua("stat flashes", 13'h0001, {9'h000, n});
        @(posedge clock);
        temp_deci <= 16'sh0105;
        wait_group(1'h1, n);
        cmp_ua("stat flashes", 13'h0002, {9'h000, n});
        @(posedge clock);
        hardware_enable_input <= 1'h0;
        tick(3);
        watch(led_stat, 30, hi, tg);
        cmp_bit("stat off", 1'h1, hi == 0);
        $display("test status done");
        for (k = 0; k < 2; k++) begin
            @(posedge clock);
            {rx_event, tx_event} <= k[0] ? 2'h1 : 2'h2;
            @(posedge clock);
            {rx_event, tx_event} <= 2'h0;
            tick(1);
            cmp_bit("led_rx", k == 0, led_rx);
            cmp_bit("led_tx", k == 1, led_tx);
            tick(2 * ACC);
        end
        @(posedge clock);
        host_conn <= 1'h1;
        rail_ok <= 6'h2A;
        tick(2);
        watch(led_rx, 20, hi, tg);
        cmp_bit("rx link toggles", 1'h1, tg == 20 / LKC);
        watch(led_tx, 20, hi, tg);
        cmp_bit("tx link toggles", 1'h1, tg == 20 / LKC);
        cmp_ua("led_rail", 13'h002A, {7'h00, led_rail});
        @(posedge clock);
        host_conn <= 1'h0;
        $display("test activity done");
        @(posedge clock);
        hardware_enable_input <= 1'h1;
        safe_req <= 1'h1;
        @(posedge clock);
        safe_req <= 1'h0;
        tick(3);
        for (k = 0; k < 30; k++) begin
            tick(1);
            cmp_bit("safe phase", 1'h1, led_err === led_stat && led_stat === led_cpu);
        end
        clear_faults();
        watch(led_cpu, 30, hi, tg);
        cmp_bit("safe blinks", 1'h1, tg > 0);
        cmp_bit("safe enable", 1'h0, final_enable);
        $display("test safe done");
        wrap_up();
    end
endmodule : tb_tci_top

//--- tci_flash_reader.sv
`timescale 1ns/10ps
module tci_flash_reader #(
    parameter int GAP = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // observed led
    input wire logic led,
    // decoded group
    output logic [3:0] flashes,
    output logic group_done
);
    // ==========================================================
    // flash group reader, as an eye on the panel would count
    logic [3:0] run_q;
    logic led_q;
    int dark_q;

    always_ff @(posedge clock) begin
        led_q <= led;
        group_done <= 1'h0;
        if (rst) begin
            run_q <= 4'h0;
            dark_q <= 0;
            flashes <= 4'h0;
        end else if (led && !led_q) begin
            run_q <= run_q + 4'h1;
            dark_q <= 0;
        end else if (led) begin
            dark_q <= 0;
        end else begin
            dark_q <= dark_q + 1;
            // long dark run ends a group, short gaps stay inside it
            if (dark_q == GAP && run_q != 4'h0) begin
                flashes <= run_q;
                group_done <= 1'h1;
                run_q <= 4'h0;
            end
        end
    end
endmodule : tci_flash_reader

//--- tci_pkg.sv
package tci_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_MHZ = 100;
    localparam int FLASH_MS = 200;
    localparam int PAUSE_MS = 1000;
    localparam int BOOT_STEP_MS = 300;
    localparam int HEART_MS = 500;
    localparam int ACT_MS = 50;
    localparam int LINK_MS = 250;
    localparam int FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
    localparam int PAUSE_CYC = PAUSE_MS * 1000 * CLK_MHZ;
    localparam int BOOT_CYC = BOOT_STEP_MS * 1000 * CLK_MHZ;
    localparam int HEART_CYC = HEART_MS * 1000 * CLK_MHZ;
    localparam int ACT_CYC = ACT_MS * 1000 * CLK_MHZ;
    localparam int LINK_CYC = LINK_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 32;
    // ==========================================================
    // sensor front end, millivolts and microamps
    localparam int MV_W = 12;
    localparam logic [MV_W-1:0] SENSE_MIN_MV = 12'h050;
    localparam logic [MV_W-1:0] SENSE_MAX_MV = 12'h8FC;
    localparam int UA_W = 13;
    localparam logic [UA_W-1:0] CUR_MIN_UA = 13'h0064;
    localparam logic [UA_W-1:0] CUR_MAX_UA = 13'h0FA0;
    localparam logic [UA_W-1:0] CUR_RST_UA = 13'h03E8;
    // ==========================================================
    // temperature in tenths of a degree
    localparam int T_W = 16;
    localparam logic [T_W-1:0] TOL_DECI = 16'h000A;
    // ==========================================================
    typedef enum logic [2:0] {
        TCI_BOOT_RED, TCI_BOOT_YEL, TCI_BOOT_GRN, TCI_RUN, TCI_SAFE
    } tci_state_t;
endpackage : tci_pkg

//--- tci_top.sv
`timescale 1ns/10ps
// Function
// [RULE_01] sensor current configurable 100 uA to 4 mA; 1 mA after reset
// [RULE_02] sensor voltage below 0,08 V means short; raise sensor error
// [RULE_03] sensor voltage above 2,30 V means open wire; raise sensor error
// [RULE_04] error led dark without fault; one flash for sensor fault
// [RULE_05] output over-current fault shows two flashes on error led
// [RULE_06] power stage over-temperature shows three flashes on error led
// [RULE_07] status led off while final enable inactive
// [RULE_08] status led steady on when enabled and within one degree
// [RULE_09] status led one flash when enabled and too cold
// [RULE_10] status led two flashes when enabled and too hot
// [RULE_11] heartbeat led toggles periodically after boot in normal operation
// [RULE_12] boot lights then clears red, yellow, green in order
// [RULE_13] safe state blinks three leds together in phase
// [RULE_14] safe state persists until power removal
// [RULE_15] receive led flashes while serial data arrives
// [RULE_16] transmit led flashes while serial data is sent
// [RULE_17] both activity leds flash periodically while host session connected
// [RULE_18] supply leds steadily on while their rails are present
// [RULE_19] output short detection is hardware, no firmware latency
// [RULE_20] fault clear input clears latched errors, not the processor
// [RULE_21] hardware enable mode: final enable follows hardware enable alone
// [RULE_22] software mode: final enable needs hardware enable and start request
// [RULE_23] flash groups use equal on and off pulses, then longer pause
// [RULE_24] coexisting faults show the lowest-numbered fault code
module tci_top #(
    parameter int FLASH_CYCLES = tci_pkg::FLASH_CYC,
    parameter int PAUSE_CYCLES = tci_pkg::PAUSE_CYC,
    parameter int BOOT_CYCLES = tci_pkg::BOOT_CYC,
    parameter int HEART_CYCLES = tci_pkg::HEART_CYC,
    parameter int ACT_CYCLES = tci_pkg::ACT_CYC,
    parameter int LINK_CYCLES = tci_pkg::LINK_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // sensor front end
    input wire logic [tci_pkg::MV_W-1:0] sense_mv,
    input wire logic [tci_pkg::UA_W-1:0] cur_req_ua,
    input wire logic cur_req_wr,
    output logic [tci_pkg::UA_W-1:0] cur_set_ua,
    output logic sensor_err,
    // power stage faults and clearing
    input wire logic out_short,
    input wire logic stage_hot,
    input wire logic fault_clear_input,
    output logic short_trip,
    // enable chain and regulation
    input wire logic hardware_enable_input,
    input wire logic sw_mode,
    input wire logic sw_start,
    input wire logic signed [tci_pkg::T_W-1:0] temp_deci,
    input wire logic signed [tci_pkg::T_W-1:0] setp_deci,
    output logic final_enable,
    // serial activity and safe state
    input wire logic rx_event,
    input wire logic tx_event,
    input wire logic host_conn,
    input wire logic safe_req,
    // supply rails
    input wire logic [5:0] rail_ok,
    // leds
    output logic led_err,
    output logic led_stat,
    output logic led_cpu,
    output logic led_red,
    output logic led_yel,
    output logic led_grn,
    output logic led_rx,
    output logic led_tx,
    output logic [5:0] led_rail
);
    import tci_pkg::*;

    // ==========================================================
    // flash code generator
    function automatic logic code_on(input logic [1:0] n, input logic [2:0] ph,
                                     input logic in_pause);
        code_on = !in_pause && (ph[0] == 1'b0) && ({1'b0, ph[2:1]} < {1'b0, n});
    endfunction : code_on

    logic [CNT_W-1:0] fl_cnt_q;
    logic [2:0] fl_ph_q;
    logic fl_pause_q;
    wire fl_tick = (fl_cnt_q == CNT_W'(FLASH_CYCLES - 1));
    wire pa_tick = (fl_cnt_q == CNT_W'(PAUSE_CYCLES - 1));

    // six half-slots cover three flashes; equal on and off, then pause
    always_ff @(posedge clock) begin
        if (rst) begin
            fl_cnt_q <= '0;
            fl_ph_q <= '0;
            fl_pause_q <= 1'b0;
        end else if (fl_pause_q) begin
            fl_cnt_q <= pa_tick ? '0 : fl_cnt_q + 1'b1; // RULE_23
            fl_pause_q <= !pa_tick;
        end else if (fl_tick) begin
            fl_cnt_q <= '0;
            fl_ph_q <= (fl_ph_q == 3'h5) ? 3'h0 : fl_ph_q + 3'h1; // RULE_23
            fl_pause_q <= (fl_ph_q == 3'h5);
        end else begin
            fl_cnt_q <= fl_cnt_q + 1'b1;
        end
    end

    // ==========================================================
    // sensor current setting
    wire cur_ok = (cur_req_ua >= CUR_MIN_UA) && (cur_req_ua <= CUR_MAX_UA);
    always_ff @(posedge clock) begin
        if (rst)
            cur_set_ua <= CUR_RST_UA; // RULE_01
        else if (cur_req_wr && cur_ok)
            cur_set_ua <= cur_req_ua; // RULE_01
    end

    // ==========================================================
    // faults; latches hold until fault_clear_input, set beats clear
    wire sens_now = (sense_mv < SENSE_MIN_MV) || (sense_mv > SENSE_MAX_MV); // RULE_02 RULE_03
    logic sens_q, short_q, hot_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            sens_q <= 1'b0;
            short_q <= 1'b0;
            hot_q <= 1'b0;
        end else begin
            sens_q <= sens_now | (sens_q & !fault_clear_input); // RULE_20
            short_q <= out_short | (short_q & !fault_clear_input); // RULE_20
            hot_q <= stage_hot | (hot_q & !fault_clear_input); // RULE_20
        end
    end
    // trip path bypasses all sequencing, no firmware latency
    assign short_trip = out_short | short_q; // RULE_19
    assign sensor_err = sens_q;

    wire [1:0] err_code = sens_q ? 2'h1 : short_q ? 2'h2 : hot_q ? 2'h3 : 2'h0; // RULE_24

    // ==========================================================
    // enable chain and regulation band
    wire fen = sw_mode ? (hardware_enable_input & sw_start) // RULE_22
                       : hardware_enable_input; // RULE_21
    // one extra bit so extreme setpoints cannot wrap the difference
    wire signed [T_W:0] diff = $signed({temp_deci[T_W-1], temp_deci})
                               - $signed({setp_deci[T_W-1], setp_deci});
    wire too_cold = diff < -$signed({1'b0, TOL_DECI});
    wire too_hot = diff > $signed({1'b0, TOL_DECI});
    wire [1:0] stat_code = too_cold ? 2'h1 : too_hot ? 2'h2 : 2'h0;

    // ==========================================================
    // boot, run and safe sequencing
    tci_state_t st_q;
    logic [CNT_W-1:0] st_cnt_q;
    logic bt_half_q;
    logic heart_q, blink_q;
    wire st_tick = (st_cnt_q == CNT_W'(BOOT_CYCLES - 1));
    wire hb_tick = (st_cnt_q == CNT_W'(HEART_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= TCI_BOOT_RED;
            st_cnt_q <= '0;
            bt_half_q <= 1'b0;
            heart_q <= 1'b0;
            blink_q <= 1'b0;
        end else begin
            case (st_q)
                TCI_BOOT_RED, TCI_BOOT_YEL, TCI_BOOT_GRN: begin
                    st_cnt_q <= st_tick ? '0 : st_cnt_q + 1'b1;
                    if (st_tick) begin
                        bt_half_q <= !bt_half_q;
                        if (bt_half_q) begin
                            case (st_q) // RULE_12
                                TCI_BOOT_RED: st_q <= TCI_BOOT_YEL;
                                TCI_BOOT_YEL: st_q <= TCI_BOOT_GRN;
                                default: st_q <= TCI_RUN;
                            endcase
                        end
                    end
                end
                TCI_RUN: begin
                    st_cnt_q <= hb_tick ? '0 : st_cnt_q + 1'b1;
                    if (hb_tick)
                        heart_q <= !heart_q; // RULE_11
                    if (safe_req) begin
                        st_q <= TCI_SAFE;
                        st_cnt_q <= '0;
                    end
                end
                default: begin
                    // no exit: only power removal leaves the safe state
                    st_q <= TCI_SAFE; // RULE_14
                    st_cnt_q <= hb_tick ? '0 : st_cnt_q + 1'b1;
                    if (hb_tick)
                        blink_q <= !blink_q; // RULE_13
                end
            endcase
        end
    end

    wire run = (st_q == TCI_RUN);
    wire safe = (st_q == TCI_SAFE);
    wire bt_lit = !bt_half_q;

    // ==========================================================
    // serial activity stretchers and host beacon
    // a new event restarts the hold, so a burst reads as one long flash
    function automatic logic [CNT_W-1:0] stretch(input logic ev, input logic [CNT_W-1:0] c);
        stretch = ev ? CNT_W'(ACT_CYCLES) : (c != '0) ? c - 1'b1 : '0;
    endfunction : stretch

    logic [CNT_W-1:0] rx_cnt_q, tx_cnt_q, ln_cnt_q;
    logic ln_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_cnt_q <= '0;
            tx_cnt_q <= '0;
            ln_cnt_q <= '0;
            ln_q <= 1'b0;
        end else begin
            rx_cnt_q <= stretch(rx_event, rx_cnt_q); // RULE_15
            tx_cnt_q <= stretch(tx_event, tx_cnt_q); // RULE_16
            if (!host_conn) begin
                ln_cnt_q <= '0;
                ln_q <= 1'b0;
            end else if (ln_cnt_q == CNT_W'(LINK_CYCLES - 1)) begin
                ln_cnt_q <= '0;
                ln_q <= !ln_q; // RULE_17
            end else begin
                ln_cnt_q <= ln_cnt_q + 1'b1;
            end
        end
    end

    // ==========================================================
    // led registers
    wire err_d = run && code_on(err_code, fl_ph_q, fl_pause_q); // RULE_04 RULE_05 RULE_06
    wire stat_d = run && fen && ((stat_code == 2'h0) // RULE_07 RULE_08
                  || code_on(stat_code, fl_ph_q, fl_pause_q)); // RULE_09 RULE_10
    always_ff @(posedge clock) begin
        if (rst) begin
            led_err <= 1'b0;
            led_stat <= 1'b0;
            led_cpu <= 1'b0;
            led_red <= 1'b0;
            led_yel <= 1'b0;
            led_grn <= 1'b0;
            led_rx <= 1'b0;
            led_tx <= 1'b0;
            led_rail <= '0;
            final_enable <= 1'b0;
        end else begin
            final_enable <= fen && !safe;
            led_err <= safe ? blink_q : err_d; // RULE_13
            led_stat <= safe ? blink_q : stat_d; // RULE_13
            led_cpu <= safe ? blink_q : (run && heart_q); // RULE_11 RULE_13
            led_red <= (st_q == TCI_BOOT_RED) && bt_lit; // RULE_12
            led_yel <= (st_q == TCI_BOOT_YEL) && bt_lit; // RULE_12
            led_grn <= (st_q == TCI_BOOT_GRN) && bt_lit; // RULE_12
            led_rx <= (rx_cnt_q != '0) || ln_q; // RULE_15 RULE_17
            led_tx <= (tx_cnt_q != '0) || ln_q; // RULE_16 RULE_17
            led_rail <= rail_ok; // RULE_18
        end
    end

    // ==========================================================
    // checks
    AST_CUR_RESET: assert property (@(posedge clock) // RULE_01
        $past(rst) && !rst |-> cur_set_ua == CUR_RST_UA)
        else $error("current not 1 mA after reset");
    AST_CUR_RANGE: assert property (@(posedge clock) disable iff (rst) // RULE_01
        cur_set_ua >= CUR_MIN_UA && cur_set_ua <= CUR_MAX_UA)
        else $error("current out of range");
    AST_SENS_LOW: assert property (@(posedge clock) disable iff (rst) // RULE_02
        sense_mv < SENSE_MIN_MV |=> sensor_err)
        else $error("short not flagged");
    AST_SENS_HIGH: assert property (@(posedge clock) disable iff (rst) // RULE_03
        sense_mv > SENSE_MAX_MV |=> sensor_err)
        else $error("open wire not flagged");
    AST_SENS_HOLD: assert property (@(posedge clock) disable iff (rst) // RULE_20
        sensor_err && !fault_clear_input |=> sensor_err)
        else $error("sensor fault dropped without clear");
    AST_ERR_DARK: assert property (@(posedge clock) disable iff (rst) // RULE_04
        run && err_code == 2'h0 |=> !led_err)
        else $error("error led lit without fault");
    AST_ERR_PRIO: assert property (@(posedge clock) disable iff (rst) // RULE_24
        run && sens_q && fl_ph_q == 3'h2 && !fl_pause_q |=> !led_err)
        else $error("other fault code shown over sensor fault");
    AST_SHORT_FAST: assert property (@(posedge clock) disable iff (rst) // RULE_19
        out_short |-> short_trip)
        else $error("short trip late");
    AST_STAT_OFF: assert property (@(posedge clock) disable iff (rst) // RULE_07
        !fen |=> !led_stat || safe)
        else $error("status lit while disabled");
    AST_STAT_STEADY: assert property (@(posedge clock) disable iff (rst) // RULE_08
        run && fen && stat_code == 2'h0 |=> led_stat)
        else $error("status dark while in band");
    AST_STAT_COLD: assert property (@(posedge clock) disable iff (rst) // RULE_09
        run && fen && too_cold && fl_ph_q == 3'h0 && !fl_pause_q |=> led_stat)
        else $error("cold flash missing");
    AST_HW_MODE: assert property (@(posedge clock) disable iff (rst) // RULE_21
        !sw_mode && !safe && !$past(safe) |=> final_enable == $past(hardware_enable_input))
        else $error("hw mode enable wrong");
    AST_SW_MODE: assert property (@(posedge clock) disable iff (rst) // RULE_22
        sw_mode && !sw_start |=> !final_enable)
        else $error("sw mode enabled without start");
    AST_CPU_BOOT: assert property (@(posedge clock) disable iff (rst) // RULE_11
        !run && !safe |=> !led_cpu)
        else $error("heartbeat before boot done");
    AST_BOOT_ONE: assert property (@(posedge clock) disable iff (rst) // RULE_12
        $onehot0({led_red, led_yel, led_grn}))
        else $error("more than one boot led lit");
    AST_SAFE_STAYS: assert property (@(posedge clock) disable iff (rst) // RULE_14
        safe |=> safe)
        else $error("safe state left");
    AST_SAFE_OFF: assert property (@(posedge clock) disable iff (rst) // RULE_14
        safe |=> !final_enable)
        else $error("enable active in safe state");
    AST_SAFE_PHASE: assert property (@(posedge clock) disable iff (rst) // RULE_13
        safe && $past(safe) |=> led_err == led_stat && led_stat == led_cpu)
        else $error("safe leds out of phase");
    AST_RX_HOLD: assert property (@(posedge clock) disable iff (rst) // RULE_15
        rx_event |-> ##2 led_rx)
        else $error("receive activity not shown");
    AST_TX_HOLD: assert property (@(posedge clock) disable iff (rst) // RULE_16
        tx_event |-> ##2 led_tx)
        else $error("transmit activity not shown");
    AST_LINK: assert property (@(posedge clock) disable iff (rst) // RULE_17
        host_conn && ln_q |=> led_rx && led_tx)
        else $error("host beacon not shown");
    AST_CLEAR: assert property (@(posedge clock) disable iff (rst) // RULE_20
        fault_clear_input && !stage_hot ##1 !stage_hot |-> !hot_q)
        else $error("latched fault not cleared");
    AST_RAIL: assert property (@(posedge clock) disable iff (rst) // RULE_18
        ##1 led_rail == $past(rail_ok))
        else $error("rail led mismatch");

    // ==========================================================
    // cover points
    COV_BOOT_DONE: cover property (@(posedge clock) disable iff (rst) st_q == TCI_BOOT_GRN ##1 run);
    COV_SAFE: cover property (@(posedge clock) disable iff (rst) run ##1 safe);
    COV_PRIO: cover property (@(posedge clock) disable iff (rst) sens_q && short_q && hot_q);
    COV_STAT_ON: cover property (@(posedge clock) disable iff (rst) led_stat && stat_code == 2'h0);
    COV_LINK: cover property (@(posedge clock) disable iff (rst) host_conn && led_rx && led_tx);
endmodule : tci_top
